// ==== ledc_regs.v ====
// display control register bank: serial frame intake, brightness, scan
// limit, option register, pwm digit scan and blink timing.
// assumes the serial clock and load strobe come from another domain and
// a host shifts 16-bit frames msb first, address in the upper byte.
`include "ledc_consts.vh"

module ledc_regs #(
  parameter OSC_DIV = `LEDC_CORE_HZ / (`LEDC_OSC_HZ * 8 * `LEDC_PWM_STEPS),
  parameter BLINK_FAST = `LEDC_CORE_HZ / 1000 * `LEDC_BLINK_FAST_MS,
  parameter BLINK_SLOW = `LEDC_CORE_HZ / 1000 * `LEDC_BLINK_SLOW_MS
) (
  input wire core_clk_i,
  input wire reset_i,
  input wire serial_clk_i,
  input wire serial_in_i,
  input wire load_strobe_i,
  output reg serial_out_o,
  output reg [7:0] digit_enable_o,
  output reg segment_enable_o,
  output reg decode_hex_o,
  output reg [7:0] option_o,
  output reg [2:0] scan_limit_o,
  output reg [31:0] brightness_o
);

  reg [2:0] sclk_sync;
  reg [2:0] sdi_sync;
  reg [2:0] load_sync;
  reg sclk_level;
  reg load_level;
  reg [15:0] shift;
  reg [7:0] option;
  reg [3:0] bright [0:7];
  reg [2:0] limit;
  reg [15:0] osc_cnt;
  reg [3:0] pwm_cnt;
  reg [2:0] digit;
  reg [31:0] blink_cnt;
  reg blink_on;
  reg blink_en_d;
  integer i;

  wire sclk_rise;
  wire load_rise;
  wire [7:0] frame_addr;
  wire [7:0] frame_data;
  wire tick;
  wire reg_res;
  wire sync_clear;
  wire [31:0] blink_half;
  wire next_lit;

  // a change counts once the second and third stages agree
  assign sclk_rise = (sclk_sync[2] == sclk_sync[1]) && sclk_sync[1]
    && !sclk_level;
  assign load_rise = (load_sync[2] == load_sync[1]) && load_sync[1]
    && !load_level;
  assign frame_addr = shift[15:8];
  assign frame_data = shift[7:0];
  assign reg_res = option[`LEDC_OPT_REG_RES];
  assign sync_clear = option[`LEDC_OPT_SYNC] && load_rise;

  // scan base tick: divided core clock or the serial clock edge
  assign tick = option[`LEDC_OPT_CLK_SEL] ? sclk_rise :
    (osc_cnt == OSC_DIV[15:0] - 16'h0001);
  assign blink_half = option[`LEDC_OPT_BLINK_SLOW] ? BLINK_SLOW :
    BLINK_FAST;

  // code n lights pwm slots 0..n, code 15 capped at 15 slots
  function lit;
    input [3:0] code;
    input [3:0] slot;
    begin
      if (code == 4'hF)
        lit = (slot < 4'hF);
      else
        lit = (slot <= code);
    end
  endfunction

  assign next_lit = lit(bright[digit], pwm_cnt);

  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_sync <= 3'h0;
      sdi_sync <= 3'h0;
      load_sync <= 3'h0;
      sclk_level <= 1'b0;
      load_level <= 1'b0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], serial_clk_i};
      sdi_sync <= {sdi_sync[1:0], serial_in_i};
      load_sync <= {load_sync[1:0], load_strobe_i};
      if (sclk_sync[2] == sclk_sync[1])
        sclk_level <= sclk_sync[1];
      if (load_sync[2] == load_sync[1])
        load_level <= load_sync[1];
    end
  end

  // shift register: oldest bit leaves on serial_out
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      shift <= 16'h0000;
      serial_out_o <= 1'b0;
    end else if (sclk_rise) begin
      shift <= {shift[14:0], sdi_sync[2]};
      serial_out_o <= shift[15];
    end
  end

  // register writes on load strobe rise
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      option <= `LEDC_OPT_RESET;
      limit <= `LEDC_LIMIT_RESET;
      for (i = 0; i < 8; i = i + 1)
        bright[i] <= `LEDC_BRIGHT_RESET;
    end else begin
      if (load_rise) begin
        case (frame_addr)
          `LEDC_ADDR_GLOBAL: begin
            for (i = 0; i < 8; i = i + 1)
              bright[i] <= frame_data[3:0];
          end
          `LEDC_ADDR_LIMIT: limit <= frame_data[2:0];
          `LEDC_ADDR_OPTION: option <= frame_data;
          `LEDC_ADDR_DIG01, `LEDC_ADDR_DIG23, `LEDC_ADDR_DIG45,
          `LEDC_ADDR_DIG67: begin
            bright[{frame_addr[1:0], 1'b0}] <= frame_data[3:0];
            bright[{frame_addr[1:0], 1'b1}] <= frame_data[7:4];
          end
          default: ;
        endcase
      end
      // defaults win while the soft reset bit stands
      if (reg_res) begin
        limit <= `LEDC_LIMIT_RESET;
        for (i = 0; i < 8; i = i + 1)
          bright[i] <= `LEDC_BRIGHT_RESET;
      end
    end
  end

  // multiplex scan: each enabled digit gets 16 pwm slots
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      osc_cnt <= 16'h0000;
      pwm_cnt <= 4'h0;
      digit <= 3'h0;
    end else if (sync_clear) begin
      osc_cnt <= 16'h0000;
      pwm_cnt <= 4'h0;
      digit <= 3'h0;
    end else begin
      if (osc_cnt == OSC_DIV[15:0] - 16'h0001)
        osc_cnt <= 16'h0000;
      else
        osc_cnt <= osc_cnt + 16'h0001;
      if (tick) begin
        pwm_cnt <= pwm_cnt + 4'h1;
        if (pwm_cnt == 4'hF)
          digit <= (digit >= limit) ? 3'h0 : digit + 3'h1;
      end
    end
  end

  // blink phase timer
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      blink_cnt <= 32'h00000000;
      blink_on <= 1'b1;
      blink_en_d <= 1'b0;
    end else begin
      blink_en_d <= option[`LEDC_OPT_BLINK_EN];
      if (sync_clear || (option[`LEDC_OPT_BLINK_EN] && !blink_en_d)) begin
        blink_cnt <= 32'h00000000;
        blink_on <= option[`LEDC_OPT_BLINK_START];
      end else if (blink_cnt >= blink_half - 32'h00000001) begin
        blink_cnt <= 32'h00000000;
        blink_on <= !blink_on;
      end else begin
        blink_cnt <= blink_cnt + 32'h00000001;
      end
    end
  end

  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      // digit 0 is the scan position held in reset, so show it one-hot
      digit_enable_o <= 8'h01;
      segment_enable_o <= 1'b0;
      decode_hex_o <= 1'b0;
      option_o <= `LEDC_OPT_RESET;
      scan_limit_o <= `LEDC_LIMIT_RESET;
      brightness_o <= 32'h00000000;
    end else begin
      digit_enable_o <= 8'h01 << digit;
      segment_enable_o <= next_lit &&
        (!option[`LEDC_OPT_BLINK_EN] || blink_on);
      decode_hex_o <= option[`LEDC_OPT_DECODE];
      option_o <= option;
      scan_limit_o <= limit;
      for (i = 0; i < 8; i = i + 1)
        brightness_o[i*4 +: 4] <= bright[i];
    end
  end

endmodule // ledc_regs

// ==== ledc_consts.vh ====
// register map, field positions and timing constants of the display
// control register bank; included by the bank module only
`ifndef LEDC_CONSTS_VH
`define LEDC_CONSTS_VH

`define LEDC_ADDR_NOP 8'h00
`define LEDC_ADDR_GLOBAL 8'h0A
`define LEDC_ADDR_LIMIT 8'h0B
`define LEDC_ADDR_OPTION 8'h0E
`define LEDC_ADDR_DIG01 8'h10
`define LEDC_ADDR_DIG23 8'h11
`define LEDC_ADDR_DIG45 8'h12
`define LEDC_ADDR_DIG67 8'h13

`define LEDC_OPT_RESET 8'h00
`define LEDC_BRIGHT_RESET 4'h0
`define LEDC_LIMIT_RESET 3'h0

`define LEDC_OPT_CLK_SEL 0
`define LEDC_OPT_REG_RES 1
`define LEDC_OPT_DECODE 2
`define LEDC_OPT_BLINK_EN 4
`define LEDC_OPT_BLINK_SLOW 5
`define LEDC_OPT_SYNC 6
`define LEDC_OPT_BLINK_START 7

`define LEDC_FRAME_BITS 16
// pwm slots per digit slot, used in the oscillator divider
`define LEDC_PWM_STEPS 16
// internal oscillator in hz, core clock in hz
`define LEDC_OSC_HZ 800
`define LEDC_CORE_HZ 10000000
// half blink periods in milliseconds
`define LEDC_BLINK_FAST_MS 500
`define LEDC_BLINK_SLOW_MS 1000
`endif

// ==== ledc_regs_asserts.sv ====
// assertions on the display register bank ports
// assumes one core clock domain; bound at the foot
module ledc_regs_asserts (
  input logic core_clk_i,
  input logic reset_i,
  input logic serial_clk_i,
  input logic load_strobe_i,
  input logic serial_out_o,
  input logic [7:0] digit_enable_o,
  input logic decode_hex_o,
  input logic [7:0] option_o,
  input logic [2:0] scan_limit_o,
  input logic [31:0] brightness_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  a_digit_onehot:
    assert property ($onehot(digit_enable_o)) else $error("scan");
  a_digit_step:
    assert property ($changed(digit_enable_o) && !digit_enable_o[0] |->
      digit_enable_o == $past(digit_enable_o) << 1) else $error("step");
  a_decode_copy:
    assert property ($stable(option_o)[*2] |-> decode_hex_o == option_o[2])
      else $error("decode");
  a_soft_reset:
    assert property ((option_o[1])[*2] |-> brightness_o == 32'h0 &&
      scan_limit_o == 3'h0) else $error("soft");
  a_load_needed:
    assert property ((!load_strobe_i)[*8] |-> $stable(option_o) &&
      $stable(brightness_o) && $stable(scan_limit_o)) else $error("load");
  a_shift_needed:
    assert property ((!serial_clk_i)[*6] |-> $stable(serial_out_o))
      else $error("shift");
  a_ext_freeze:
    assert property ((option_o[0] && !serial_clk_i)[*8] |->
      $stable(digit_enable_o)) else $error("ext");
  a_sync_clear:
    assert property (option_o[6] && $rose(load_strobe_i) |->
      ##[3:8] digit_enable_o == 8'h01) else $error("sync");
  cover property ($rose(option_o[0]));
  cover property ($rose(option_o[1]));
  cover property ($rose(option_o[6]));
endmodule // ledc_regs_asserts

bind ledc_regs ledc_regs_asserts ledc_regs_asserts_inst (.*);

// ==== ledc_host_model.sv ====
// host side of the serial link: frames msb first, then a strobe
// assumes the bench calls its tasks; clock and strobe idle low between frames, data holds the last bit
module ledc_host_model (
  input logic core_clk_i,
  input logic serial_out_i,
  output logic serial_clk_o = 1'b0,
  output logic serial_in_o = 1'b0,
  output logic load_strobe_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // got collects what the device pushes out meanwhile
  task automatic shift(input logic [15:0] w, output logic [15:0] got);
    for (int i = 0; i < 16; i++) begin
      serial_clk_o <= 1'b0;
      serial_in_o <= w[15-i];
      repeat (4) @(posedge core_clk_i);
      got = {got[14:0], serial_out_i};
      serial_clk_o <= 1'b1;
      repeat (4) @(posedge core_clk_i);
    end
    serial_clk_o <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    got = {got[14:0], serial_out_i};
  endtask
  task automatic load();
    load_strobe_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    load_strobe_o <= 1'b0;
    repeat (12) @(posedge core_clk_i);
  endtask
endmodule // ledc_host_model

// ==== ledc_regs_tb_top.sv ====
// bench of the display register bank
// assumes the host model owns the link pins
module ledc_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  wire sclk, serial_in, ld, serial_out, seg, hex;
  wire [7:0] dig, opt;
  wire [2:0] lim;
  wire [31:0] bri;
  logic [31:0] e;
  logic [15:0] g;
  int n_fail = 0, n_tests = 0, p, lit, p7;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t %0h %0h", $time, a, b); end end
  initial forever #50 core_clk_i = ~core_clk_i;
  ledc_regs #(.OSC_DIV(4), .BLINK_FAST(64), .BLINK_SLOW(128))
    ledc_regs_inst (.core_clk_i, .reset_i, .serial_clk_i(sclk),
    .serial_in_i(serial_in), .load_strobe_i(ld), .serial_out_o(serial_out),
    .digit_enable_o(dig), .segment_enable_o(seg), .decode_hex_o(hex),
    .option_o(opt), .scan_limit_o(lim), .brightness_o(bri));
  ledc_host_model ledc_host_model_inst (.core_clk_i, .serial_out_i(serial_out),
    .serial_clk_o(sclk), .serial_in_o(serial_in), .load_strobe_o(ld));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ledc_host_model_inst.shift({a, d}, g);
    ledc_host_model_inst.load();
    @(negedge core_clk_i);
  endtask
  // one full scan between two starts of digit 0
  task automatic scan();
    p = 0;
    lit = 0;
    @(posedge dig[0]);
    fork
      @(posedge dig[0]);
      forever @(negedge core_clk_i) begin
        p++;
        lit += seg;
      end
    join_any
    disable fork;
  endtask
  // count lit segment samples over a fixed number of cycles
  task automatic win(input int c);
    lit = 0;
    repeat (c) @(negedge core_clk_i) lit += seg;
  endtask
  task automatic tally_and_finish();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #4000000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(negedge core_clk_i);
    `CHK({opt, bri, lim}, 43'h0)
    wr(8'h0A, 8'h5C);
    e = 32'hCCCCCCCC;
    `CHK(bri, e)
    for (int j = 0; j < 4; j++) begin
      e[8*j +: 8] = 8'h10 + 8'h22 * 8'(j);
      wr(8'h10 + 8'(j), e[8*j +: 8]);
      `CHK(bri, e)
    end
    wr(8'h0B, 8'hFD);
    wr(8'h00, 8'hFF);
    `CHK({bri, lim}, {e, 3'h5})
    ledc_host_model_inst.shift(16'h0A77, g);
    ledc_host_model_inst.shift(16'h0000, g);
    ledc_host_model_inst.load();
    @(negedge core_clk_i);
    `CHK({g, bri}, {16'h0A77, e})
    $display("write done");
    wr(8'h0B, 8'h07);
    for (int n = 0; n < 16; n += 5) begin
      wr(8'h0A, 8'(n));
      scan();
      `CHK(lit * 16, p * (n == 15 ? 15 : n + 1))
    end
    p7 = p;
    for (int k = 1; k < 7; k += 2) begin
      wr(8'h0B, 8'(k));
      scan();
      `CHK(p * 8, p7 * (k + 1))
    end
    $display("scan done");
    wr(8'h0E, 8'h0D);
    `CHK({hex, opt}, 9'h10D)
    wr(8'h0E, 8'h02);
    wr(8'h0A, 8'h55);
    `CHK({opt, bri, lim}, {8'h02, 35'h0})
    wr(8'h0E, 8'h40);
    wr(8'h0B, 8'h07);
    `CHK({dig, lim}, 11'h00F)
    $display("option done");
    wr(8'h0E, 8'h00);
    wr(8'h0A, 8'h0F);
    wr(8'h0E, 8'h10);
    win(40);
    `CHK(lit, 0)
    win(64);
    `CHK(lit != 0, 1'b1)
    wr(8'h0E, 8'h00);
    wr(8'h0E, 8'h30);
    win(100);
    `CHK(lit, 0)
    wr(8'h0E, 8'h00);
    wr(8'h0E, 8'h90);
    win(40);
    `CHK(lit != 0, 1'b1)
    $display("blink done");
    tally_and_finish();
  end
endmodule // ledc_regs_tb_top
